// >>> pkg/tmc_pkg.sv
// Package with constants, types and reset values of the timer/counter
package tmc_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [4:0] OFS_CTL  = 5'h00;
	localparam logic [4:0] OFS_CTL2 = 5'h04;
	localparam logic [4:0] OFS_LOW  = 5'h08;
	localparam logic [4:0] OFS_HIGH = 5'h0c;
	localparam logic [4:0] OFS_STAT = 5'h10;
	localparam logic [4:0] OFS_MASK = 5'h14;

	// ==========================================================
	// Field positions
	localparam int CTL_EN_BIT     = 7;
	localparam int CTL_OUT_BIT    = 5;
	localparam int CTL_WIDTH_BIT  = 4;
	localparam int CTL_POST_LSB   = 0;
	localparam int CTL2_SRC_BIT   = 5;
	localparam int CTL2_ASYNC_BIT = 4;
	localparam int CTL2_PRE_LSB   = 0;
	localparam logic [7:0] CTL_WMASK = 8'hdf;

	// ==========================================================
	// Widths and counts
	localparam int PRE_W = 15;
	localparam int SEL_W = 4;
	localparam logic [1:0] INSTR_DIV = 2'h3;

	// ==========================================================
	// Reset values
	localparam logic [7:0] CTL_RST  = 8'h00;
	localparam logic [7:0] CTL2_RST = 8'h00;
	localparam logic [7:0] LOW_RST  = 8'h00;
	localparam logic [7:0] HIGH_RST = 8'hff;

	// ==========================================================
	// Bus states
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_WRITE = 3'b010,
		BUS_READ  = 3'b100
	} tmc_bus_t;

	// ==========================================================
	// Whole state of the timer top except hresp_reg
	typedef struct packed {
		tmc_bus_t    bus;
		logic [4:0]  addr;
		logic [7:0]  ctl;
		logic [7:0]  ctl2;
		logic [7:0]  low;
		logic [7:0]  high_true;
		logic [7:0]  high_buf;
		logic [7:0]  period_buf;
		logic        status;
		logic        mask;
		logic        irq;
		logic        tout;
		logic        tpulse;
		logic [1:0]  div;
		logic        sync1;
		logic        sync2;
		logic        sync_prev;
		logic        raw_prev;
		logic [31:0] rdata;
		logic        hready;
	} tmc_state_t;

	localparam tmc_state_t TMC_STATE_RST = '{
		bus: BUS_IDLE, addr: 5'h00, ctl: CTL_RST, ctl2: CTL2_RST,
		low: LOW_RST, high_true: 8'h00, high_buf: HIGH_RST,
		period_buf: HIGH_RST, status: 1'b0, mask: 1'b0, irq: 1'b0,
		tout: 1'b0, tpulse: 1'b0, div: 2'h0, sync1: 1'b0, sync2: 1'b0,
		sync_prev: 1'b0, raw_prev: 1'b0, rdata: 32'h0000_0000,
		hready: 1'b1
	};

	typedef struct packed {
		logic [14:0] cnt;
	} tmc_pre_t;

	typedef struct packed {
		logic [3:0] cnt;
	} tmc_post_t;

endpackage

// >>> sim/testbench.sv
// Self-checking testbench of the timer/counter
`timescale 1ns/1ps
module testbench;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        ext_clk_in;
	logic        sleep_mode;
	logic        timer_out;
	logic        timer_out_pulse;
	logic        irq;
	logic [15:0] pulse_count;
	logic [15:0] last_gap;
	logic [31:0] rd;
	int          mismatches;
	int          comparisons;
	int          cycles;

	initial hclk = 1'b0;
	always #5 hclk = ~hclk;

	tmc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ext_clk_in(ext_clk_in), .sleep_mode(sleep_mode), .timer_out(timer_out),
		.timer_out_pulse(timer_out_pulse), .irq(irq));

	tmc_far_side u_far (.hclk(hclk), .hresetn(hresetn), .timer_out_pulse(timer_out_pulse),
		.ext_clk_in(ext_clk_in), .pulse_count(pulse_count), .last_gap(last_gap));

	// ====================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ====================================
	// Bus cycles
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {27'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(rd, {24'h0, e});
		check({31'h0, hresp}, 32'h0);
	endtask

	task automatic do_reset();
		@(posedge hclk);
		hresetn <= 1'b0;
		sleep_mode <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	task automatic wait_pulse();
		logic [15:0] n;
		n = pulse_count;
		for (int i = 0; i < 4000 && pulse_count === n; i++) @(posedge hclk);
		check({16'h0, pulse_count - n}, 32'h1);
	endtask

	// ====================================
	// Scenarios
	task automatic t_reset();
		do_reset();
		rdc(tmc_pkg::OFS_CTL, 8'h00);
		rdc(tmc_pkg::OFS_CTL2, 8'h00);
		rdc(tmc_pkg::OFS_HIGH, 8'hff);
		rdc(tmc_pkg::OFS_STAT, 8'h00);
		rdc(tmc_pkg::OFS_MASK, 8'h00);
		rdc(5'h18, 8'h00);
		repeat (40) @(posedge hclk);
		rdc(tmc_pkg::OFS_LOW, 8'h00);
		check({30'h0, timer_out, irq}, 32'h0);
	endtask

	task automatic t_period(input int pre, input int post);
		logic to;
		do_reset();
		wr(tmc_pkg::OFS_HIGH, 8'h02);
		wr(tmc_pkg::OFS_LOW, 8'hfd);
		wr(tmc_pkg::OFS_CTL2, pre[7:0]);
		wr(tmc_pkg::OFS_CTL, 8'h80 | post[7:0]);
		wait_pulse();
		to = timer_out;
		wait_pulse();
		check({16'h0, last_gap}, 32'(12 * (1 << pre) * (post + 1)));
		check({31'h0, timer_out}, {31'h0, ~to});
		rdc(tmc_pkg::OFS_CTL, 8'h80 | post[7:0] | {2'h0, ~to, 5'h0});
	endtask

	task automatic t_irq();
		do_reset();
		wr(tmc_pkg::OFS_HIGH, 8'h02);
		wr(tmc_pkg::OFS_LOW, 8'hfd);
		wr(tmc_pkg::OFS_CTL2, 8'h04);
		wr(tmc_pkg::OFS_MASK, 8'h01);
		wr(tmc_pkg::OFS_CTL, 8'h80);
		wait_pulse();
		repeat (2) @(posedge hclk);
		check({31'h0, irq}, 32'h1);
		rdc(tmc_pkg::OFS_STAT, 8'h01);
		repeat (2) @(posedge hclk);
		check({31'h0, irq}, 32'h0);
		rdc(tmc_pkg::OFS_STAT, 8'h00);
		wr(tmc_pkg::OFS_MASK, 8'h00);
		wait_pulse();
		repeat (2) @(posedge hclk);
		check({31'h0, irq}, 32'h0);
		rdc(tmc_pkg::OFS_STAT, 8'h01);
	endtask

	task automatic t_wide();
		logic [15:0] n;
		do_reset();
		wr(tmc_pkg::OFS_CTL, 8'h10);
		wr(tmc_pkg::OFS_HIGH, 8'h12);
		wr(tmc_pkg::OFS_LOW, 8'h34);
		wr(tmc_pkg::OFS_HIGH, 8'h56);
		rdc(tmc_pkg::OFS_LOW, 8'h34);
		rdc(tmc_pkg::OFS_HIGH, 8'h12);
		wr(tmc_pkg::OFS_HIGH, 8'h00);
		wr(tmc_pkg::OFS_LOW, 8'hfe);
		n = pulse_count;
		wr(tmc_pkg::OFS_CTL, 8'h90);
		repeat (40) @(posedge hclk);
		wr(tmc_pkg::OFS_CTL, 8'h10);
		check({16'h0, pulse_count}, {16'h0, n});
		bus(1'b0, tmc_pkg::OFS_LOW, 8'h00);
		rdc(tmc_pkg::OFS_HIGH, 8'h01);
		wr(tmc_pkg::OFS_HIGH, 8'hff);
		wr(tmc_pkg::OFS_LOW, 8'hfe);
		wr(tmc_pkg::OFS_CTL, 8'h90);
		wait_pulse();
		wr(tmc_pkg::OFS_CTL, 8'h10);
		bus(1'b0, tmc_pkg::OFS_LOW, 8'h00);
		rdc(tmc_pkg::OFS_HIGH, 8'h00);
	endtask

	task automatic t_ext(input logic as, input logic slp, input logic [7:0] e);
		do_reset();
		sleep_mode <= slp;
		wr(tmc_pkg::OFS_CTL2, {2'h0, 1'b1, as, 4'h0});
		wr(tmc_pkg::OFS_CTL, 8'h90);
		u_far.make_edges(5);
		repeat (8) @(posedge hclk);
		wr(tmc_pkg::OFS_CTL, 8'h10);
		rdc(tmc_pkg::OFS_LOW, e);
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sleep_mode = 1'b0;
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		t_reset();
		t_period(0, 0);
		t_period(1, 0);
		t_period(4, 0);
		t_period(0, 2);
		t_period(0, 15);
		t_irq();
		t_wide();
		t_ext(1'b1, 1'b0, 8'h05);
		t_ext(1'b0, 1'b0, 8'h05);
		t_ext(1'b1, 1'b1, 8'h05);
		t_ext(1'b0, 1'b1, 8'h00);
		tally_and_finish();
	end
endmodule

// >>> sim/tmc_far_side.sv
// Far-side model: external count source and consumer of the timer output
`timescale 1ns/1ps
module tmc_far_side (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        timer_out_pulse,
	output logic             ext_clk_in,
	output logic [15:0]      pulse_count,
	output logic [15:0]      last_gap
);
	logic [15:0] gap;

	initial ext_clk_in = 1'b0;

	// ====================================
	// Rising edges, each level held four clocks, idle low
	task automatic make_edges(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge hclk);
			ext_clk_in <= 1'b1;
			repeat (4) @(posedge hclk);
			ext_clk_in <= 1'b0;
		end
	endtask

	// ====================================
	// Pulse count and cycles between pulses
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_count <= 16'h0000;
			last_gap    <= 16'h0000;
			gap         <= 16'h0000;
		end else if (timer_out_pulse === 1'b1) begin
			pulse_count <= pulse_count + 16'h0001;
			last_gap    <= gap + 16'h0001;
			gap         <= 16'h0000;
		end else begin
			gap <= gap + 16'h0001;
		end
	end
endmodule

// >>> src/tmc_postscaler.sv
// Divide-by-(sel+1) postscaler on match and rollover events
`timescale 1ns/1ps
module tmc_postscaler (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      event_in,
	input  wire logic                      clear,
	input  wire logic [tmc_pkg::SEL_W-1:0] sel,
	output logic                           pulse
);
	tmc_pkg::tmc_post_t s_reg;
	tmc_pkg::tmc_post_t s_next;

	// ==========================================================
	// One pulse every sel+1 events
	always_comb begin
		pulse = event_in && !clear && (s_reg.cnt >= sel);
		s_next = s_reg;
		if (clear || pulse) begin
			s_next.cnt = 4'h0;
		end else if (event_in) begin
			s_next.cnt = s_reg.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// >>> src/tmc_prescaler.sv
// Power-of-two prescaler in front of the count
`timescale 1ns/1ps
module tmc_prescaler (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      tick,
	input  wire logic                      clear,
	input  wire logic [tmc_pkg::SEL_W-1:0] sel,
	output logic                           pulse
);
	tmc_pkg::tmc_pre_t s_reg;
	tmc_pkg::tmc_pre_t s_next;
	logic [14:0]       mask;

	// ==========================================================
	// Ratio 2**sel from the low bits of the count
	always_comb begin
		mask = 15'((16'h0001 << sel) - 16'h0001);
		pulse = tick && !clear && ((s_reg.cnt & mask) == mask);
		s_next = s_reg;
		if (clear) begin
			s_next.cnt = 15'h0000;
		end else if (tick) begin
			s_next.cnt = s_reg.cnt + 15'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// >>> src/tmc_timer.sv
// Top of the 8/16-bit timer/counter with its AHB-Lite register slave
`timescale 1ns/1ps
module tmc_timer (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_clk_in,
	input  wire logic        sleep_mode,
	output logic             timer_out,
	output logic             timer_out_pulse,
	output logic             irq
);
	tmc_pkg::tmc_state_t s_reg;
	tmc_pkg::tmc_state_t s_next;

	logic       en;
	logic       wide;
	logic       ext_sel;
	logic       async_sel;
	logic       instr_tick;
	logic       ext_rise;
	logic       src_tick;
	logic       tick;
	logic       pre_pulse;
	logic       post_pulse;
	logic       match8;
	logic       wrap16;
	logic       count_event;
	logic       clr;
	logic       addr_ok;
	logic       wr;
	logic       rd;
	logic [7:0] rd_byte;
	logic       hresp_reg;

	// ==========================================================
	// Mode decode
	always_comb begin
		en = s_reg.ctl[tmc_pkg::CTL_EN_BIT];
		wide = s_reg.ctl[tmc_pkg::CTL_WIDTH_BIT];
		ext_sel = s_reg.ctl2[tmc_pkg::CTL2_SRC_BIT];
		async_sel = s_reg.ctl2[tmc_pkg::CTL2_ASYNC_BIT];
		instr_tick = (s_reg.div == tmc_pkg::INSTR_DIV) && !sleep_mode;
		if (async_sel) begin
			ext_rise = ext_clk_in && !s_reg.raw_prev;
		end else begin
			ext_rise = s_reg.sync2 && !s_reg.sync_prev;
		end
		src_tick = ext_sel ? ext_rise : instr_tick;
		tick = en && src_tick && (async_sel || !sleep_mode);
	end

	// ==========================================================
	// Bus decode
	always_comb begin
		addr_ok = hsel && htrans[1] && hready;
		wr = (s_reg.bus == tmc_pkg::BUS_WRITE);
		rd = (s_reg.bus == tmc_pkg::BUS_READ);
		clr = !en || (wr && ((s_reg.addr == tmc_pkg::OFS_LOW) ||
			(s_reg.addr == tmc_pkg::OFS_CTL) ||
			(s_reg.addr == tmc_pkg::OFS_CTL2)));
	end

	// ==========================================================
	// Prescaler and postscaler
	tmc_prescaler u_pre (
		.clk   (hclk),
		.rst_n (hresetn),
		.tick  (tick),
		.clear (clr),
		.sel   (s_reg.ctl2[tmc_pkg::CTL2_PRE_LSB +: tmc_pkg::SEL_W]),
		.pulse (pre_pulse)
	);

	always_comb begin
		match8 = !wide && pre_pulse && (s_reg.low == s_reg.period_buf);
		wrap16 = wide && pre_pulse && ({s_reg.high_true, s_reg.low} == 16'hffff);
		count_event = match8 || wrap16;
	end

	tmc_postscaler u_post (
		.clk      (hclk),
		.rst_n    (hresetn),
		.event_in (count_event),
		.clear    (clr),
		.sel      (s_reg.ctl[tmc_pkg::CTL_POST_LSB +: tmc_pkg::SEL_W]),
		.pulse    (post_pulse)
	);

	// ==========================================================
	// Read mux
	always_comb begin
		case (s_reg.addr)
			tmc_pkg::OFS_CTL: begin
				rd_byte = s_reg.ctl;
				rd_byte[tmc_pkg::CTL_OUT_BIT] = s_reg.tout;
			end
			tmc_pkg::OFS_CTL2: begin
				rd_byte = s_reg.ctl2;
			end
			tmc_pkg::OFS_LOW: begin
				rd_byte = s_reg.low;
			end
			tmc_pkg::OFS_HIGH: begin
				rd_byte = s_reg.high_buf;
			end
			tmc_pkg::OFS_STAT: begin
				rd_byte = {7'h00, s_reg.status};
			end
			tmc_pkg::OFS_MASK: begin
				rd_byte = {7'h00, s_reg.mask};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.tpulse = 1'b0;
		s_next.div = s_reg.div + 2'h1;
		s_next.sync1 = ext_clk_in;
		s_next.sync2 = s_reg.sync1;
		s_next.sync_prev = s_reg.sync2;
		s_next.raw_prev = ext_clk_in;

		// Counting
		if (pre_pulse) begin
			if (wide) begin
				{s_next.high_true, s_next.low} =
					{s_reg.high_true, s_reg.low} + 16'h0001;
			end else if (match8) begin
				s_next.low = 8'h00;
				s_next.period_buf = s_reg.high_buf;
			end else begin
				s_next.low = s_reg.low + 8'h01;
			end
		end

		// Read side effects
		if (rd) begin
			s_next.rdata = {24'h000000, rd_byte};
			if (wide && (s_reg.addr == tmc_pkg::OFS_LOW)) begin
				s_next.high_buf = s_reg.high_true;
			end
			if (s_reg.addr == tmc_pkg::OFS_STAT) begin
				s_next.status = 1'b0;
			end
		end

		// Postscaled event wins over a status clear
		if (post_pulse) begin
			s_next.status = 1'b1;
			s_next.tout = !s_reg.tout;
			s_next.tpulse = 1'b1;
		end

		// Register writes
		if (wr) begin
			case (s_reg.addr)
				tmc_pkg::OFS_CTL: begin
					s_next.ctl = hwdata[7:0] & tmc_pkg::CTL_WMASK;
				end
				tmc_pkg::OFS_CTL2: begin
					s_next.ctl2 = hwdata[7:0];
				end
				tmc_pkg::OFS_LOW: begin
					s_next.low = hwdata[7:0];
					if (wide) begin
						s_next.high_true = s_reg.high_buf;
					end
				end
				tmc_pkg::OFS_HIGH: begin
					s_next.high_buf = hwdata[7:0];
				end
				tmc_pkg::OFS_MASK: begin
					s_next.mask = hwdata[0];
				end
				default: begin
				end
			endcase
		end

		// Bus phases
		case (s_reg.bus)
			tmc_pkg::BUS_IDLE, tmc_pkg::BUS_WRITE: begin
				if (addr_ok) begin
					s_next.addr = haddr[4:0];
					s_next.bus = hwrite ? tmc_pkg::BUS_WRITE : tmc_pkg::BUS_READ;
					s_next.hready = hwrite;
				end else begin
					s_next.bus = tmc_pkg::BUS_IDLE;
					s_next.hready = 1'b1;
				end
			end
			tmc_pkg::BUS_READ: begin
				s_next.bus = tmc_pkg::BUS_IDLE;
				s_next.hready = 1'b1;
			end
			default: begin
				s_next.bus = tmc_pkg::BUS_IDLE;
				s_next.hready = 1'b1;
			end
		endcase

		s_next.irq = s_next.status && s_next.mask;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= tmc_pkg::TMC_STATE_RST;
			hresp_reg <= 1'b0;
		end else begin
			s_reg <= s_next;
			hresp_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	assign hrdata = s_reg.rdata;
	assign hreadyout = s_reg.hready;
	assign hresp = hresp_reg;
	assign timer_out = s_reg.tout;
	assign timer_out_pulse = s_reg.tpulse;
	assign irq = s_reg.irq;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_irq_level: assert property (irq == (s_reg.status && s_reg.mask))
		else $error("irq does not follow status and mask");
	a_idle_hold: assert property (!en && !wr |=> $stable(s_reg.low))
		else $error("count moved while disabled");
	a_pre_unity: assert property (
		tick && !clr && (s_reg.ctl2[3:0] == 4'h0) |-> pre_pulse)
		else $error("1:1 prescale missed a tick");
	a_match_clear: assert property (match8 && !wr |=> s_reg.low == 8'h00)
		else $error("low count not cleared on match");
	a_wrap_zero: assert property (wrap16 && !wr |=>
		{s_reg.high_true, s_reg.low} == 16'h0000)
		else $error("16-bit count did not wrap");
	a_read_latch: assert property (
		rd && wide && s_reg.addr == tmc_pkg::OFS_LOW
		|=> s_reg.high_buf == $past(s_reg.high_true))
		else $error("high byte not latched on low read");
	a_write_load: assert property (
		wr && wide && s_reg.addr == tmc_pkg::OFS_LOW
		|=> s_reg.high_true == $past(s_reg.high_buf))
		else $error("high byte not loaded on low write");
	a_sleep_halt: assert property (sleep_mode && !async_sel |-> !tick)
		else $error("synchronous count ran in sleep");
	a_post_unity: assert property (
		count_event && !clr && (s_reg.ctl[3:0] == 4'h0) |-> post_pulse)
		else $error("1:1 postscale missed an event");
	a_out_toggle: assert property (
		post_pulse |=> timer_out != $past(timer_out) && timer_out_pulse && s_reg.status)
		else $error("output or flag missed a postscaled event");
	a_read_wait: assert property (
		addr_ok && !hwrite && s_reg.bus != tmc_pkg::BUS_READ
		|=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	// ==========================================================
	// Count, flag, output and scaler assertions
	a_stat_clear: assert property (
		rd && s_reg.addr == tmc_pkg::OFS_STAT && !post_pulse |=> !s_reg.status)
		else $error("status not cleared by its read");
	a_set_wins: assert property (
		post_pulse && rd && s_reg.addr == tmc_pkg::OFS_STAT |=> s_reg.status)
		else $error("status clear beat a same-cycle event");
	a_status_sticky: assert property (
		s_reg.status && !(rd && s_reg.addr == tmc_pkg::OFS_STAT) |=> s_reg.status)
		else $error("status dropped without a read");
	a_mask_write: assert property (
		wr && s_reg.addr == tmc_pkg::OFS_MASK |=> s_reg.mask == $past(hwdata[0]))
		else $error("mask write did not land");
	a_clr_scalers: assert property (
		clr |=> u_pre.s_reg.cnt == 15'h0000 && u_post.s_reg.cnt == 4'h0)
		else $error("scalers not cleared");
	a_period_load: assert property (match8 |=> s_reg.period_buf == $past(s_reg.high_buf))
		else $error("period buffer not reloaded on match");
	a_step_low: assert property (
		pre_pulse && !wide && !match8 && !wr |=> s_reg.low == $past(s_reg.low) + 8'h01)
		else $error("8-bit count did not step by one");
	a_step_wide: assert property (
		pre_pulse && wide && !wr |=>
		{s_reg.high_true, s_reg.low} == $past({s_reg.high_true, s_reg.low}) + 16'h0001)
		else $error("16-bit count did not step by one");
	a_out_hold: assert property (!post_pulse |=> $stable(timer_out))
		else $error("output moved without an event");
	a_out_ro: assert property (
		wr && s_reg.addr == tmc_pkg::OFS_CTL |=> !s_reg.ctl[tmc_pkg::CTL_OUT_BIT])
		else $error("output bit of control register was written");
	a_instr_gap: assert property (!ext_sel && tick && !wr |=> !tick)
		else $error("internal ticks closer than one instruction cycle");
	a_async_edge: assert property (
		en && ext_sel && async_sel && ext_clk_in && !s_reg.raw_prev && !clr
		&& (s_reg.ctl2[3:0] == 4'h0) |-> pre_pulse)
		else $error("external rising edge not counted");
	a_sync_edge: assert property (
		en && ext_sel && !async_sel && !sleep_mode && s_reg.sync2 && !s_reg.sync_prev
		&& !clr && (s_reg.ctl2[3:0] == 4'h0) |-> pre_pulse)
		else $error("synchronised edge not counted");

	// ==========================================================
	// Covers
	c_match8: cover property (match8);
	c_wrap16: cover property (wrap16);
	c_irq_rise: cover property ($rose(irq));
	c_sleep_async: cover property (sleep_mode && async_sel && tick);
	c_post_div: cover property (post_pulse && s_reg.ctl[3:0] != 4'h0);
endmodule
